// ### src/bpp_pkg.sv
// Purpose: constants for the bidirectional printer port
// Assumes: host strobes and printer lines are asynchronous to clk
// Notes:   register offsets are the two address bits
// Function
// R01: address 00 data, 01 select/status, 10 control
// R02: status read clears interrupt output and flag
// R03: direction: control bit5, pin, magic AA
// R04: data register maps onto eight data lines
// R05: status bits busy inverted, ack, pe, sel, fault, irq
// R06: readback ones, irq enable, four line states
// R07: control write sets direction, irq enable, lines
// R08: ack falling edge marks interrupt pending
// R09: strobe, linefeed, select active low; init high
// R10: reset gives output mode, irq enable clear
// R11: reset clears pending interrupt flag
package bpp_pkg;
    // ***********************************
    // register offsets
    // ***********************************
    localparam logic [1:0] BPP_OFF_DATA   = 2'h0;
    localparam logic [1:0] BPP_OFF_STATUS = 2'h1;
    localparam logic [1:0] BPP_OFF_CTRL   = 2'h2;
    localparam logic [1:0] BPP_OFF_NONE   = 2'h3;
    // ***********************************
    // fields and values
    // ***********************************
    localparam logic [7:0] BPP_INPUT_KEY  = 8'hAA;
    localparam int         BPP_CTL_DIR    = 5;
    localparam int         BPP_CTL_IRQEN  = 4;
    localparam logic [7:0] BPP_RESET_BYTE = 8'h00;
    localparam logic [5:0] BPP_CTL_RESET  = 6'h00;
    localparam logic [2:0] BPP_RB_ONES    = 3'h7;
    localparam logic [1:0] BPP_ST_ONES    = 2'h3;
    localparam logic [3:0] BPP_PINS_RESET = 4'hB;
    localparam logic [2:0] BPP_SYNC_IDLE  = 3'h7;
    localparam logic [7:0] BPP_UNMAPPED   = 8'hFF;
endpackage : bpp_pkg

// ### src/bpp_port.sv
// Purpose: bidirectional printer port, host side registers to printer pins
// Assumes: single clock; strobes sampled through two flip-flops
// Notes:   access acts on the sampled strobe falling edge
`timescale 1ns/1ps
module bpp_port
    import bpp_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // host register port
    input  wire logic       reg_addr_hi,
    input  wire logic       reg_addr_lo,
    input  wire logic       host_read_n,
    input  wire logic       host_write_n,
    input  wire logic [7:0] host_wdata,
    output logic      [7:0] host_rdata,
    // printer data lines
    input  wire logic [7:0] port_data_lines_in,
    output logic      [7:0] port_data_lines_out,
    output logic            port_data_lines_oe,
    // printer handshake
    output logic            byte_latch_n,
    output logic            auto_linefeed_n,
    output logic            init_out,
    output logic            select_request_n,
    input  wire logic       busy,
    input  wire logic       ack_n,
    input  wire logic       paper_empty,
    input  wire logic       printer_selected,
    input  wire logic       fault_n,
    input  wire logic       direction_pin,
    // interrupt
    output logic            printer_irq_out
);
    import bpp_pkg::*;

    typedef struct packed {
        logic [2:0] rd_s;
        logic [2:0] wr_s;
        logic [2:0] ack_s;
        logic [1:0] dir_s;
        logic [1:0] ad_s0;
        logic [1:0] ad_s1;
        logic [7:0] wd_s0;
        logic [7:0] wd_s1;
        logic [3:0] in_s0;
        logic [3:0] in_s1;
        logic [7:0] pd_s0;
        logic [7:0] pd_s1;
        logic [7:0] data;
        logic [5:0] ctl;
        logic       key_ok;
        logic       pend;
        logic [7:0] rdata;
        logic       oe;
        logic [3:0] pins;
        logic       irq;
    } bpp_state_t;

    bpp_state_t s_q;
    bpp_state_t s_d;
    logic [1:0] addr;
    logic       rd_fall;
    logic       wr_fall;
    logic       ack_fall;
    logic       in_mode;
    logic [7:0] status;
    logic [7:0] rback;

    // address and data pass the same two stages as the strobes
    assign addr = s_q.ad_s1;

    // ***********************************
    // next state
    // ***********************************
    always_comb
    begin
        s_d       = s_q;
        s_d.rd_s  = {s_q.rd_s[1:0], host_read_n};
        s_d.wr_s  = {s_q.wr_s[1:0], host_write_n};
        s_d.ack_s = {s_q.ack_s[1:0], ack_n};
        s_d.dir_s = {s_q.dir_s[0], direction_pin};
        // host data must stand at the first edge after the strobe falls, together with the strobe
        s_d.ad_s0 = {reg_addr_hi, reg_addr_lo};
        s_d.ad_s1 = s_q.ad_s0;
        s_d.wd_s0 = host_wdata;
        s_d.wd_s1 = s_q.wd_s0;
        s_d.in_s0 = {busy, paper_empty, printer_selected, fault_n};
        s_d.in_s1 = s_q.in_s0;
        s_d.pd_s0 = port_data_lines_in;
        s_d.pd_s1 = s_q.pd_s0;
        // bit 2 is history of the synced level; bit 0 may be metastable
        rd_fall  = s_q.rd_s[2] & ~s_q.rd_s[1];
        wr_fall  = s_q.wr_s[2] & ~s_q.wr_s[1];
        ack_fall = s_q.ack_s[2] & ~s_q.ack_s[1];
        in_mode  = ~s_q.ctl[BPP_CTL_DIR] & (s_q.dir_s[1] | s_q.key_ok); // R03
        status   = {~s_q.in_s1[3], s_q.ack_s[1], s_q.in_s1[2], s_q.in_s1[1],
                    s_q.in_s1[0], ~s_q.pend, BPP_ST_ONES}; // R05
        rback    = {BPP_RB_ONES, s_q.ctl[4], s_q.ctl[3:0]}; // R06
        if (wr_fall)
        begin
            case (addr) // R01
                BPP_OFF_DATA:   s_d.data   = s_q.wd_s1; // R04
                BPP_OFF_STATUS: s_d.key_ok = (s_q.wd_s1 == BPP_INPUT_KEY); // R03
                BPP_OFF_CTRL:   s_d.ctl    = s_q.wd_s1[5:0]; // R07
                default:        s_d.data   = s_q.data;
            endcase
        end
        if (rd_fall)
        begin
            case (addr) // R01
                BPP_OFF_DATA:   s_d.rdata = in_mode ? s_q.pd_s1 : s_q.data; // R04
                BPP_OFF_STATUS: s_d.rdata = status;
                BPP_OFF_CTRL:   s_d.rdata = rback;
                default:        s_d.rdata = BPP_UNMAPPED;
            endcase
        end
        // pending: a new ack edge wins over the clearing read
        if (rd_fall && addr == BPP_OFF_STATUS)
            s_d.pend = 1'b0; // R02
        if (ack_fall)
            s_d.pend = 1'b1; // R08
        s_d.oe   = ~in_mode; // R03
        // strobe, linefeed, select inverted; init straight
        s_d.pins = {~s_d.ctl[3], s_d.ctl[2], ~s_d.ctl[1], ~s_d.ctl[0]}; // R09
        s_d.irq  = s_d.pend & s_d.ctl[BPP_CTL_IRQEN]; // R08
    end

    // ***********************************
    // registers
    // ***********************************
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_q        <= '0;
            s_q.rd_s   <= BPP_SYNC_IDLE;
            s_q.wr_s   <= BPP_SYNC_IDLE;
            s_q.ack_s  <= BPP_SYNC_IDLE;
            s_q.ctl    <= BPP_CTL_RESET; // R10
            s_q.pend   <= 1'b0; // R11
            s_q.data   <= BPP_RESET_BYTE;
            s_q.oe     <= 1'b1; // R10
            s_q.pins   <= BPP_PINS_RESET;
        end
        else
            s_q <= s_d;
    end

    assign host_rdata          = s_q.rdata;
    assign port_data_lines_out = s_q.data;
    assign port_data_lines_oe  = s_q.oe;
    assign select_request_n    = s_q.pins[3];
    assign init_out            = s_q.pins[2];
    assign auto_linefeed_n     = s_q.pins[1];
    assign byte_latch_n        = s_q.pins[0];
    assign printer_irq_out     = s_q.irq;

    // ***********************************
    // checks
    // ***********************************
    // a status read and an ack edge in one cycle leave the flag set
    sequence s_clear_rd;
        rd_fall && addr == BPP_OFF_STATUS && !ack_fall;
    endsequence
    sequence s_status_rd;
        rd_fall && addr == BPP_OFF_STATUS;
    endsequence
    sequence s_ctl_wr;
        wr_fall && addr == BPP_OFF_CTRL;
    endsequence

    // interrupt
    a_irq_gated: assert property (@(posedge clk) disable iff (!resetn) // R08
        printer_irq_out |-> s_q.ctl[BPP_CTL_IRQEN])
        else $error("irq out while disabled");
    a_status_clear: assert property (@(posedge clk) disable iff (!resetn) // R02
        s_clear_rd |=> !s_q.pend && !printer_irq_out)
        else $error("status read did not clear");
    a_ack_pend: assert property (@(posedge clk) disable iff (!resetn) // R08
        ack_fall |=> s_q.pend && s_q.irq == s_q.ctl[BPP_CTL_IRQEN])
        else $error("ack edge lost");

    // direction
    a_force_out: assert property (@(posedge clk) disable iff (!resetn) // R03
        s_q.ctl[BPP_CTL_DIR] |=> port_data_lines_oe)
        else $error("direction bit ignored");
    a_key_input: assert property (@(posedge clk) disable iff (!resetn) // R03
        (!s_q.ctl[BPP_CTL_DIR] && s_q.key_ok) |=> !port_data_lines_oe)
        else $error("key did not select input");
    a_pin_input: assert property (@(posedge clk) disable iff (!resetn) // R03
        (!s_q.ctl[BPP_CTL_DIR] && s_q.dir_s[1]) |=> !port_data_lines_oe)
        else $error("direction pin ignored");
    a_key_output: assert property (@(posedge clk) disable iff (!resetn) // R03
        (!s_q.ctl[BPP_CTL_DIR] && !s_q.dir_s[1] && !s_q.key_ok) |=> port_data_lines_oe)
        else $error("other key did not select output");

    // control and pins
    a_ctl_write: assert property (@(posedge clk) disable iff (!resetn) // R07
        s_ctl_wr |=> s_q.ctl == $past(s_q.wd_s1[5:0]))
        else $error("control write lost");
    a_pin_levels: assert property (@(posedge clk) disable iff (!resetn) // R09
        byte_latch_n == !s_q.ctl[0] && auto_linefeed_n == !s_q.ctl[1]
        && init_out == s_q.ctl[2] && select_request_n == !s_q.ctl[3])
        else $error("pin polarity wrong");

    // register reads and writes
    a_rback_ones: assert property (@(posedge clk) disable iff (!resetn) // R06
        (rd_fall && addr == BPP_OFF_CTRL) |=> host_rdata[7:5] == BPP_RB_ONES
        && host_rdata[4:0] == $past(s_q.ctl[4:0]))
        else $error("readback wrong");
    a_status_ones: assert property (@(posedge clk) disable iff (!resetn) // R05
        s_status_rd |=> host_rdata[1:0] == BPP_ST_ONES)
        else $error("status low bits");
    a_status_irq: assert property (@(posedge clk) disable iff (!resetn) // R05
        s_status_rd |=> host_rdata[2] == !$past(s_q.pend)
        && host_rdata[7] == !$past(s_q.in_s1[3]))
        else $error("status flag or busy wrong");
    a_data_write: assert property (@(posedge clk) disable iff (!resetn) // R04
        (wr_fall && addr == BPP_OFF_DATA) |=> port_data_lines_out == $past(s_q.wd_s1))
        else $error("data write lost");
    a_input_read: assert property (@(posedge clk) disable iff (!resetn) // R04
        (rd_fall && addr == BPP_OFF_DATA && in_mode) |=> host_rdata == $past(s_q.pd_s1))
        else $error("input read wrong");
    a_output_read: assert property (@(posedge clk) disable iff (!resetn) // R04
        (rd_fall && addr == BPP_OFF_DATA && !in_mode) |=> host_rdata == $past(s_q.data))
        else $error("output read wrong");
    a_unmapped: assert property (@(posedge clk) disable iff (!resetn) // R01
        (wr_fall && addr == BPP_OFF_NONE) |=> $stable(s_q.ctl) && $stable(s_q.data)
        && $stable(s_q.key_ok))
        else $error("unmapped write changed state");
endmodule : bpp_port

// ### tb/bpp_printer.sv
// Purpose: printer side model for the port bench
// Assumes: bench asks for each acknowledge pulse
// Notes:   lines carry val while the port lets go, its inverse while the port drives
`timescale 1ns/1ps
module bpp_printer
(
    // clock
    input  wire logic       clk,
    // bench requests
    input  wire logic       ack_go,
    input  wire logic [7:0] val,
    // port side
    input  wire logic       oe,
    output logic      [7:0] drv,
    output logic            ack_n
);
    // ******
    // handshake
    // ******
    logic [2:0] n_q = 3'h0;
    // lines flip while the port drives, so a stale value never passes
    assign drv   = oe ? ~val : val;
    assign ack_n = n_q == 3'h0;
    always @(posedge clk)
        if (ack_go)
            n_q <= 3'h6;
        else if (n_q != 3'h0)
            n_q <= n_q - 3'h1;
endmodule : bpp_printer

// ### tb/bpp_port_tb.sv
// Purpose: self-checking bench for the printer port
// Assumes: strobes held 4 clk low and 4 clk high
// Notes:   reads queue a note, a monitor compares
`timescale 1ns/1ps
module bpp_port_tb;
    import bpp_pkg::*;
    // ******
    // wiring
    // ******
    logic       clk = 0, resetn = 0, rn = 1, wn = 1, pin = 0, go = 0;
    logic [1:0] a = 2'h0;
    logic [3:0] st = 4'h5;
    logic [7:0] wd = 8'h0, v = 8'h0, rd, lo, ln, dv, q[$];
    logic       oe, bl, af, ini, sr, irq, ak;
    int         seed = 32'h6d88, bad_count = 0, cmp_count = 0;
    event       ev;
    always #20 clk = ~clk;
    assign ln = oe ? lo : dv;
    bpp_printer prn (.clk(clk), .ack_go(go), .val(v), .oe(oe), .drv(dv), .ack_n(ak));
    bpp_port dut (.clk(clk), .resetn(resetn), .reg_addr_hi(a[1]), .reg_addr_lo(a[0]),
        .host_read_n(rn), .host_write_n(wn), .host_wdata(wd), .host_rdata(rd),
        .port_data_lines_in(ln), .port_data_lines_out(lo), .port_data_lines_oe(oe),
        .byte_latch_n(bl), .auto_linefeed_n(af), .init_out(ini), .select_request_n(sr),
        .busy(st[3]), .ack_n(ak), .paper_empty(st[2]), .printer_selected(st[1]),
        .fault_n(st[0]), .direction_pin(pin), .printer_irq_out(irq));
    task automatic chk(input logic [7:0] s, e, input string n);
        cmp_count++;
        if (s !== e)
        begin
            bad_count++;
            $display("MISMATCH %s exp %h saw %h", n, e, s);
        end
    endtask : chk
    task automatic acc(input logic [1:0] ad, input logic r, input logic [7:0] d);
        @(posedge clk) #1;
        a = ad;
        wd = d;
        rn = !r;
        wn = r;
        repeat (4) @(posedge clk);
        #1 rn = 1;
        wn = 1;
        repeat (4) @(posedge clk);
        #1;
    endtask : acc
    task automatic rdx(input logic [1:0] ad, input logic [7:0] e);
        q.push_back(e);
        acc(ad, 1, 8'h00);
        ->ev;
    endtask : rdx
    task automatic pulse;
        @(posedge clk) #1 go = 1;
        @(posedge clk) #1 go = 0;
        repeat (12) @(posedge clk);
        #1;
    endtask : pulse
    function automatic logic [7:0] sx(input logic p);
        return {~st[3], ak, st[2:0], p, 2'h3};
    endfunction : sx
    task automatic close_out;
        $display("counts: %0d compares, %0d mismatches", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : close_out
    always @(ev) chk(rd, q.pop_front(), "rdata");
    initial
    begin
        repeat (5000) @(posedge clk);
        bad_count++;
        close_out();
    end
    // ******
    // scenarios
    // ******
    initial
    begin
        repeat (3) @(posedge clk);
        #1 resetn = 1;
        chk({oe, irq, bl, ini}, 8'h0A, "reset pins");
        rdx(2, 8'hE0);
        rdx(3, 8'hFF);
        rdx(1, sx(1));
        acc(3, 0, 8'h3F);
        rdx(2, 8'hE0);
        $display("test reset done");
        for (int i = 0; i < 8; i++)
        begin
            v = $random(seed);
            st = v[7:4];
            v[5] = 1'b0;
            acc(2, 0, v);
            chk({bl, af, ini, sr}, {~v[0], ~v[1], v[2], ~v[3]}, "pins");
            rdx(2, {3'h7, v[4:0]});
            rdx(1, sx(1));
        end
        $display("test control done");
        for (int i = 0; i < 4; i++)
        begin
            pin = i == 1;
            acc(2, 0, {2'h0, i == 0, 5'h0});
            acc(1, 0, i[0] ? 8'h55 : 8'hAA);
            v = $random(seed);
            chk(oe, i == 0 || i == 3, "direction");
            if (!oe)
                rdx(0, v);
        end
        $display("test direction done");
        pin = 0;
        acc(2, 0, 8'h00);
        v = $random(seed);
        acc(0, 0, v);
        chk(lo, v, "lines out");
        rdx(0, v);
        $display("test data done");
        acc(2, 0, 8'h10);
        pulse();
        chk(irq, 1, "irq set");
        rdx(1, sx(0));
        chk(irq, 0, "irq clear");
        rdx(1, sx(1));
        acc(2, 0, 8'h00);
        pulse();
        chk(irq, 0, "irq masked");
        $display("test interrupt done");
        close_out();
    end
endmodule : bpp_port_tb
